// File: frc_pkg.sv
// Purpose: constants, types and default tables for the factory reset controller
// Assumes: 10 MHz system clock, registers reached over AXI4-Lite
// Notes: feedback fields are stored in units of 0.01 mm, top half positive, bottom half negative magnitude
// How it works
// R1: all three keys held about 2.5 s enters reset pending
// R2: while pending the indicator alternates red 500 ms and green 500 ms
// R3: pending with no reset for 10 s is left with settings untouched
// R4: a second 2.5 s three-key hold while pending restores factory settings
// R5: after the reset the fault colour blinks 250 ms on, 250 ms off
// R6: service software command resets exactly like the key sequence
// R7: reset untaughts positions, restores fields, counters, intervals, notification off, manual on
// R8: reset turns the service notification off, so no interval elapse is signalled
// R9: reset disables the upper disc check by external sensor four
// R10: reset disables reporting external sensor four as position one
// R11: reset disables all-valves-together; option ignored on double-acting variants
// R12: total cycle counters and total run time survive the reset
// R13: colour option, averaging, bus address, profile and input assembly survive
// R14: field defaults are 3.00 mm for positions one, two and 1.00 mm for three
// R15: interval defaults 10000, 50000, 50000 cycles and 365 days
// R16: resettable run time and cycle counters return to zero
// R17: releasing any key before the threshold aborts the hold
package frc_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned HOLD_MS = 2500;
  localparam int unsigned HOLD_CYC = HOLD_MS * CYC_PER_MS;
  localparam int unsigned PEND_HALF_MS = 500;
  localparam int unsigned PEND_HALF_CYC = PEND_HALF_MS * CYC_PER_MS;
  localparam int unsigned PEND_TMO_MS = 10000;
  localparam int unsigned PEND_TMO_CYC = PEND_TMO_MS * CYC_PER_MS;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
  localparam int unsigned CONFIRM_BLINKS = 3;

  localparam int AXI_AW = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_TAUGHT = 6'h02;
  localparam logic [5:0] IDX_OPTIONS = 6'h03;
  localparam logic [5:0] IDX_FB1 = 6'h04;
  localparam logic [5:0] IDX_FB2 = 6'h05;
  localparam logic [5:0] IDX_FB3 = 6'h06;
  localparam logic [5:0] IDX_SVC1 = 6'h07;
  localparam logic [5:0] IDX_SVC2 = 6'h08;
  localparam logic [5:0] IDX_SVC3 = 6'h09;
  localparam logic [5:0] IDX_SVC_DAYS = 6'h0A;
  localparam logic [5:0] IDX_CYC1 = 6'h0B;
  localparam logic [5:0] IDX_CYC3 = 6'h0D;
  localparam logic [5:0] IDX_RUN = 6'h0E;
  localparam logic [5:0] IDX_TOT1 = 6'h0F;
  localparam logic [5:0] IDX_TOT3 = 6'h11;
  localparam logic [5:0] IDX_TOT_RUN = 6'h12;
  localparam logic [5:0] IDX_BUS_ADDR = 6'h13;
  localparam logic [5:0] IDX_BUS_PROFILE = 6'h14;
  localparam logic [5:0] IDX_INPUT_ASSY = 6'h15;

  localparam int CTRL_CMD_BIT = 0;
  localparam int OPT_SVC_NOTIFY = 0;
  localparam int OPT_MANUAL_MAG = 1;
  localparam int OPT_S4_DISC = 2;
  localparam int OPT_S4_AS_P1 = 3;
  localparam int OPT_ALL_VALVES = 4;
  localparam int OPT_S3S4_COLOUR = 5;
  localparam int OPT_AVERAGING = 6;
  localparam logic [31:0] OPT_KEEP_MASK = 32'h0000_0060;
  localparam logic [31:0] OPT_DEF = 32'h0000_0002;
  localparam logic [31:0] FB12_DEF = 32'h012C_012C;
  localparam logic [31:0] FB3_DEF = 32'h0064_0064;
  localparam logic [31:0] SVC1_DEF = 32'h0000_2710;
  localparam logic [31:0] SVC23_DEF = 32'h0000_C350;
  localparam logic [31:0] SVC_DAYS_DEF = 32'h0000_016D;
  localparam logic [31:0] BUS_ADDR_DEF = 32'h0000_0000;

  typedef enum logic [1:0] {
    FRC_IDLE = 2'b00,
    FRC_PENDING = 2'b01,
    FRC_CONFIRM = 2'b10
  } frc_state_e;

  typedef struct packed {
    logic red;
    logic green;
    logic fault;
  } frc_ind_s;

  typedef struct packed {
    logic svc_notify;
    logic manual_mag;
    logic s4_disc_mon;
    logic s4_as_pos1;
    logic all_valves;
    logic s3s4_colour;
    logic averaging;
  } frc_opt_s;

  // value a stored register takes at power-on, and at factory reset for registers not kept
  function automatic logic [31:0] frc_default(input logic [5:0] idx);
    case (idx)
      IDX_OPTIONS: frc_default = OPT_DEF;
      IDX_FB1, IDX_FB2: frc_default = FB12_DEF;
      IDX_FB3: frc_default = FB3_DEF;
      IDX_SVC1: frc_default = SVC1_DEF;
      IDX_SVC2, IDX_SVC3: frc_default = SVC23_DEF;
      IDX_SVC_DAYS: frc_default = SVC_DAYS_DEF;
      IDX_BUS_ADDR: frc_default = BUS_ADDR_DEF;
      default: frc_default = 32'h0000_0000;
    endcase
  endfunction : frc_default

  // value after a factory reset, keeping what must survive
  function automatic logic [31:0] frc_factory(input logic [5:0] idx, input logic [31:0] cur);
    if (idx == IDX_OPTIONS) begin
      frc_factory = (cur & OPT_KEEP_MASK) | (OPT_DEF & ~OPT_KEEP_MASK);
    end else if (idx >= IDX_TOT1) begin
      frc_factory = cur;
    end else begin
      frc_factory = frc_default(idx);
    end
  endfunction : frc_factory

endpackage : frc_pkg

// File: frc_hold_timer.sv
// Purpose: detect a continuous three-key hold of a fixed length
// Assumes: key levels already debounced and synchronous to clk_sys_i
// Notes: a hold fires once; keys must be released before another hold counts
`timescale 1ns/1ps
module frc_hold_timer #(
  parameter int unsigned HOLD_CYC = frc_pkg::HOLD_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [2:0] keys_i,
  output logic fire_o
);

  logic [31:0] cnt_r;
  logic armed_r;
  logic all_held;

  assign all_held = &keys_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 32'h0000_0000;
      armed_r <= 1'b0;
      fire_o <= 1'b0;
    end else begin
      fire_o <= 1'b0;
      if (!all_held) begin
        cnt_r <= 32'h0000_0000; // [R17]
        armed_r <= 1'b1;
      end else if (armed_r) begin
        if (cnt_r == HOLD_CYC - 1) begin
          fire_o <= 1'b1; // [R1] [R4]
          armed_r <= 1'b0;
          cnt_r <= 32'h0000_0000;
        end else begin
          cnt_r <= cnt_r + 32'h0000_0001;
        end
      end
    end
  end

endmodule : frc_hold_timer

// File: frc_top.sv
// Purpose: factory reset controller with key sequence, indicator and settings store
// Assumes: keys and counter ticks synchronous to clk_sys_i; one AXI4-Lite master
// Notes: counter registers are read-only; long times are parameters to allow short simulation
`timescale 1ns/1ps
module frc_top #(
  parameter int unsigned HOLD_CYC = frc_pkg::HOLD_CYC,
  parameter int unsigned PEND_HALF_CYC = frc_pkg::PEND_HALF_CYC,
  parameter int unsigned PEND_TMO_CYC = frc_pkg::PEND_TMO_CYC,
  parameter int unsigned BLINK_HALF_CYC = frc_pkg::BLINK_HALF_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic key_one_i,
  input wire logic key_two_i,
  input wire logic key_three_i,
  input wire logic [2:0] cycle_tick_i,
  input wire logic day_tick_i,
  input wire logic double_acting_i,
  input wire logic [frc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [frc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output frc_pkg::frc_ind_s ind_o,
  output frc_pkg::frc_opt_s opt_o,
  output logic [2:0] taught_o,
  output logic svc_due_o,
  output logic reset_done_o
);

  frc_pkg::frc_state_e state_r;
  logic [31:0] store_r [frc_pkg::IDX_TAUGHT:frc_pkg::IDX_INPUT_ASSY];
  logic fire;
  logic cmd_pulse;
  logic factory_go;
  logic [31:0] tmo_r;
  logic [31:0] half_r;
  logic phase_r;
  logic [2:0] halves_r;
  logic aw_held_r;
  logic w_held_r;
  logic [5:0] wr_idx_r;
  logic wr_misaligned_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic wr_mapped;
  logic [5:0] rd_idx;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [31:0] status_word;

  frc_hold_timer #(
    .HOLD_CYC(HOLD_CYC)
  ) u_hold (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .keys_i({key_three_i, key_two_i, key_one_i}),
    .fire_o(fire)
  );

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] frc_strb(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction : frc_strb

  // true for an index that holds a counter, which software cannot overwrite
  function automatic logic frc_is_counter(input logic [5:0] idx);
    return (idx >= frc_pkg::IDX_CYC1) && (idx <= frc_pkg::IDX_TOT_RUN);
  endfunction : frc_is_counter

  // write channel: address and data are taken in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_mapped = !wr_misaligned_r && (wr_idx_r <= frc_pkg::IDX_INPUT_ASSY);
  assign cmd_pulse = wr_go && (wr_idx_r == frc_pkg::IDX_CTRL) && !wr_misaligned_r
                     && wstrb_r[0] && wdata_r[frc_pkg::CTRL_CMD_BIT]; // [R6]

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      wr_idx_r <= 6'h00;
      wr_misaligned_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      wr_idx_r <= s_axi_awaddr[7:2];
      wr_misaligned_r <= |s_axi_awaddr[1:0];
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= frc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? frc_pkg::RESP_OKAY : frc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = s_axi_araddr[7:2];
  assign status_word = {26'h000_0000, ind_o, svc_due_o, state_r};

  always_comb begin
    rd_ok = (s_axi_araddr[1:0] == 2'h0) && (rd_idx <= frc_pkg::IDX_INPUT_ASSY);
    if (!rd_ok || rd_idx == frc_pkg::IDX_CTRL) begin
      rd_val = 32'h0000_0000;
    end else if (rd_idx == frc_pkg::IDX_STATUS) begin
      rd_val = status_word;
    end else begin
      rd_val = store_r[rd_idx];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= frc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? frc_pkg::RESP_OKAY : frc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // the second hold counts only while pending; a hold in idle arms pending
  assign factory_go = cmd_pulse || (fire && state_r == frc_pkg::FRC_PENDING); // [R4] [R6]

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= frc_pkg::FRC_IDLE;
      tmo_r <= 32'h0000_0000;
      half_r <= 32'h0000_0000;
      phase_r <= 1'b0;
      halves_r <= 3'h0;
    end else begin
      if (factory_go) begin
        state_r <= frc_pkg::FRC_CONFIRM;
        half_r <= 32'h0000_0000;
        phase_r <= 1'b0;
        halves_r <= 3'h0;
      end else begin
        case (state_r)
          frc_pkg::FRC_IDLE: begin
            tmo_r <= 32'h0000_0000;
            half_r <= 32'h0000_0000;
            phase_r <= 1'b0;
            if (fire) begin
              state_r <= frc_pkg::FRC_PENDING; // [R1]
            end
          end
          frc_pkg::FRC_PENDING: begin
            if (tmo_r == PEND_TMO_CYC - 1) begin
              state_r <= frc_pkg::FRC_IDLE; // [R3]
            end
            tmo_r <= tmo_r + 32'h0000_0001;
            if (half_r == PEND_HALF_CYC - 1) begin
              half_r <= 32'h0000_0000;
              phase_r <= !phase_r; // [R2]
            end else begin
              half_r <= half_r + 32'h0000_0001;
            end
          end
          frc_pkg::FRC_CONFIRM: begin
            if (half_r == BLINK_HALF_CYC - 1) begin
              half_r <= 32'h0000_0000;
              phase_r <= !phase_r; // [R5]
              halves_r <= halves_r + 3'h1;
              if (halves_r == 3'(2 * frc_pkg::CONFIRM_BLINKS - 1)) begin
                state_r <= frc_pkg::FRC_IDLE;
              end
            end else begin
              half_r <= half_r + 32'h0000_0001;
            end
          end
          default: begin
            state_r <= frc_pkg::FRC_IDLE;
          end
        endcase
      end
    end
  end

  // indicator: pending starts red, confirm starts with fault colour on
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ind_o <= '0;
    end else begin
      ind_o.red <= (state_r == frc_pkg::FRC_PENDING) && !phase_r; // [R2]
      ind_o.green <= (state_r == frc_pkg::FRC_PENDING) && phase_r; // [R2]
      ind_o.fault <= (state_r == frc_pkg::FRC_CONFIRM) && !phase_r; // [R5]
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_done_o <= 1'b0;
    end else begin
      reset_done_o <= factory_go;
    end
  end

  // settings store; factory reset wins over a write or a tick in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = frc_pkg::IDX_TAUGHT; i <= frc_pkg::IDX_INPUT_ASSY; i++) begin
        store_r[i] <= frc_pkg::frc_default(6'(i));
      end
    end else begin
      for (int i = frc_pkg::IDX_TAUGHT; i <= frc_pkg::IDX_INPUT_ASSY; i++) begin
        if (factory_go) begin
          // [R7] [R8] [R9] [R10] [R11] [R12] [R13] [R14] [R15] [R16]
          store_r[i] <= frc_pkg::frc_factory(6'(i), store_r[i]);
        end else if (wr_go && wr_mapped && wr_idx_r == 6'(i) && !frc_is_counter(6'(i))) begin
          store_r[i] <= frc_strb(store_r[i], wdata_r, wstrb_r);
        end else if (i >= frc_pkg::IDX_CYC1 && i <= frc_pkg::IDX_CYC3 && cycle_tick_i[i - 11]) begin
          store_r[i] <= store_r[i] + 32'h0000_0001;
        end else if (i == frc_pkg::IDX_RUN && day_tick_i) begin
          store_r[i] <= store_r[i] + 32'h0000_0001;
        end else if (i >= frc_pkg::IDX_TOT1 && i <= frc_pkg::IDX_TOT3 && cycle_tick_i[i - 15]) begin
          store_r[i] <= store_r[i] + 32'h0000_0001; // [R12]
        end else if (i == frc_pkg::IDX_TOT_RUN && day_tick_i) begin
          store_r[i] <= store_r[i] + 32'h0000_0001; // [R12]
        end
      end
    end
  end

  // option outputs; all-valves has no effect on double-acting heads
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt_o <= '0;
      taught_o <= 3'h0;
    end else begin
      opt_o.svc_notify <= store_r[frc_pkg::IDX_OPTIONS][frc_pkg::OPT_SVC_NOTIFY];
      opt_o.manual_mag <= store_r[frc_pkg::IDX_OPTIONS][frc_pkg::OPT_MANUAL_MAG];
      opt_o.s4_disc_mon <= store_r[frc_pkg::IDX_OPTIONS][frc_pkg::OPT_S4_DISC];
      opt_o.s4_as_pos1 <= store_r[frc_pkg::IDX_OPTIONS][frc_pkg::OPT_S4_AS_P1];
      opt_o.all_valves <= store_r[frc_pkg::IDX_OPTIONS][frc_pkg::OPT_ALL_VALVES]
                          && !double_acting_i; // [R11]
      opt_o.s3s4_colour <= store_r[frc_pkg::IDX_OPTIONS][frc_pkg::OPT_S3S4_COLOUR];
      opt_o.averaging <= store_r[frc_pkg::IDX_OPTIONS][frc_pkg::OPT_AVERAGING];
      taught_o <= store_r[frc_pkg::IDX_TAUGHT][2:0];
    end
  end

  // maintenance due only while the notification is switched on
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      svc_due_o <= 1'b0;
    end else begin
      svc_due_o <= store_r[frc_pkg::IDX_OPTIONS][frc_pkg::OPT_SVC_NOTIFY] && !factory_go // [R8]
                   && ((store_r[frc_pkg::IDX_CYC1] >= store_r[frc_pkg::IDX_SVC1])
                   || (store_r[frc_pkg::IDX_CYC1 + 6'h01] >= store_r[frc_pkg::IDX_SVC2])
                   || (store_r[frc_pkg::IDX_CYC3] >= store_r[frc_pkg::IDX_SVC3])
                   || (store_r[frc_pkg::IDX_RUN] >= store_r[frc_pkg::IDX_SVC_DAYS]));
    end
  end

endmodule : frc_top

// File: frc_monitor.sv
// Purpose: port checker for the factory reset controller
// Assumes: timing parameters handed on by the bind
// Notes: run counters measure how long the keys are held and the red, fault and pending lamp phases last
`timescale 1ns/1ps
module frc_monitor #(
  parameter int unsigned HOLD_CYC = 20,
  parameter int unsigned PEND_HALF_CYC = 4,
  parameter int unsigned PEND_TMO_CYC = 60,
  parameter int unsigned BLINK_HALF_CYC = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic key_one_i,
  input wire logic key_two_i,
  input wire logic key_three_i,
  input wire logic double_acting_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire frc_pkg::frc_ind_s ind_o,
  input wire frc_pkg::frc_opt_s opt_o,
  input wire logic [2:0] taught_o,
  input wire logic svc_due_o,
  input wire logic reset_done_o
);
  logic pend;
  int unsigned hold_r;
  int unsigned red_r;
  int unsigned flt_r;
  int unsigned pnd_r;
  assign pend = ind_o.red | ind_o.green;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_r <= 0;
      red_r <= 0;
      flt_r <= 0;
      pnd_r <= 0;
    end else begin
      hold_r <= (key_one_i & key_two_i & key_three_i) ? hold_r + 1 : 0;
      red_r <= ind_o.red ? red_r + 1 : 0;
      flt_r <= ind_o.fault ? flt_r + 1 : 0;
      pnd_r <= pend ? pnd_r + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  a_pend_hold: assert property ($rose(pend) |-> hold_r >= HOLD_CYC - 1)
    else $error("pending entered without a full hold");
  a_red_len: assert property ($fell(ind_o.red) && ind_o.green |-> red_r == PEND_HALF_CYC)
    else $error("red phase length wrong");
  a_pend_tmo: assert property (pend |-> pnd_r <= PEND_TMO_CYC + 1)
    else $error("pending outlived its timeout");
  a_blink_len: assert property ($fell(ind_o.fault) |-> flt_r == BLINK_HALF_CYC)
    else $error("fault blink length wrong");
  a_done_blink: assert property (reset_done_o |-> ##[0:2] ind_o.fault)
    else $error("no fault blink after reset");
  a_cmd_done: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == 8'h00 && s_axi_wdata[0] |-> ##[1:3] reset_done_o)
    else $error("command gave no reset");
  a_done_dflt: assert property (reset_done_o |=> taught_o == 3'h0 && !opt_o.svc_notify
    && opt_o.manual_mag && !opt_o.s4_disc_mon && !opt_o.s4_as_pos1 && !opt_o.all_valves)
    else $error("options not at defaults after reset");
  a_done_keep: assert property (reset_done_o |=> opt_o.s3s4_colour == $past(opt_o.s3s4_colour, 2)
    && opt_o.averaging == $past(opt_o.averaging, 2))
    else $error("kept options changed by reset");
  a_done_nodue: assert property (reset_done_o |-> !svc_due_o)
    else $error("service due after reset");
  a_dbl_block: assert property (double_acting_i && $past(double_acting_i)
    && $past(double_acting_i, 2) |-> !opt_o.all_valves)
    else $error("all valves option live on double acting head");
  c_pend: cover property ($rose(pend));
  c_tmo: cover property ($fell(pend) && !ind_o.fault);
  c_done: cover property (reset_done_o);
endmodule : frc_monitor
bind frc_top frc_monitor #(.HOLD_CYC(HOLD_CYC), .PEND_HALF_CYC(PEND_HALF_CYC),
  .PEND_TMO_CYC(PEND_TMO_CYC), .BLINK_HALF_CYC(BLINK_HALF_CYC)) frc_monitor_inst (.*);

// File: frc_keypad_model.sv
// Purpose: operator keypad stand-in for the three local keys
// Assumes: keys change just after a rising edge
// Notes: a hold is a run of sampled edges with the chosen keys down
`timescale 1ns/1ps
module frc_keypad_model (
  input wire logic clk_sys_i,
  output logic [2:0] keys_o
);
  initial keys_o = 3'h0;
  // a partial mask or short count is how an aborted hold is made
  task automatic press(input int n, input logic [2:0] mask);
    @(posedge clk_sys_i);
    keys_o <= mask;
    repeat (n) @(posedge clk_sys_i);
    keys_o <= 3'h0;
  endtask : press
endmodule : frc_keypad_model

// File: testbench.sv
// Purpose: self-checking bench for the factory reset controller
// Assumes: shortened hold, pending and blink counts
// Notes: ready and valid are sampled at the falling edge, wready at the rising edge
`timescale 1ns/1ps
module testbench;
  localparam int unsigned HOLD = 20;
  localparam int unsigned TMO = 60;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [2:0] keys;
  logic [2:0] cycle_tick_i = 3'h0;
  logic day_tick_i = 1'h0;
  logic double_acting_i = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h0;
  frc_pkg::frc_ind_s ind_o;
  frc_pkg::frc_opt_s opt_o;
  logic [2:0] taught_o;
  logic svc_due_o;
  logic reset_done_o;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int dones = 0;
  int d0;
  int n;
  logic [2:0] seen;
  logic [1:0] r;
  logic [31:0] d;
  frc_keypad_model frc_keypad_model_inst (.clk_sys_i(clk_sys_i), .keys_o(keys));
  frc_top #(.HOLD_CYC(HOLD), .PEND_HALF_CYC(4), .PEND_TMO_CYC(TMO), .BLINK_HALF_CYC(3)) frc_top_inst (
    .key_one_i(keys[0]), .key_two_i(keys[1]), .key_three_i(keys[2]), .*);
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (reset_done_o === 1'h1) dones <= dones + 1;
    if (cycles == 4000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_p;
    logic w_p;
    logic t;
    aw_p = 1'h1;
    w_p = 1'h1;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw_p || w_p) begin
      @(negedge clk_sys_i);
      t = s_axi_awready;
      @(posedge clk_sys_i);
      if (aw_p && t === 1'h1) s_axi_awvalid <= 1'h0;
      if (t === 1'h1) aw_p = 1'h0;
      if (w_p && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_wready === 1'h1) w_p = 1'h0;
    end
    do begin
      @(negedge clk_sys_i);
      t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys_i);
    end while (t !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk_sys_i);
      t = s_axi_arready;
      @(posedge clk_sys_i);
    end while (t !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge clk_sys_i);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys_i);
    end while (t !== 1'h1);
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk($sformatf("reg %h", a), exp, d);
  endtask : rchk
  task automatic tick(input logic [2:0] c, input logic dy);
    @(posedge clk_sys_i);
    cycle_tick_i <= c;
    day_tick_i <= dy;
    @(posedge clk_sys_i);
    cycle_tick_i <= 3'h0;
    day_tick_i <= 1'h0;
  endtask : tick
  // counts cycles until every lamp is dark, noting which lit
  task automatic wait_dark(input int lim);
    n = 0;
    seen = 3'h0;
    do begin
      @(negedge clk_sys_i);
      seen = seen | ind_o;
      n++;
    end while (ind_o !== 3'h0 && n < lim);
  endtask : wait_dark
  task automatic t_defaults();
    rchk(8'h0C, 32'h0000_0002);
    rchk(8'h10, 32'h012C_012C);
    rchk(8'h18, 32'h0064_0064);
    rchk(8'h1C, 32'h0000_2710);
    rchk(8'h24, 32'h0000_C350);
    rchk(8'h28, 32'h0000_016D);
    rd(8'h58);
    chk("unmapped resp", 32'h2, {30'h0, r});
    $display("defaults done");
  endtask : t_defaults
  task automatic t_abort();
    frc_keypad_model_inst.press(HOLD - 2, 3'h7);
    repeat (4) @(negedge clk_sys_i);
    chk("short hold", 32'h0, {29'h0, ind_o});
    frc_keypad_model_inst.press(HOLD + 6, 3'h3);
    repeat (4) @(negedge clk_sys_i);
    chk("two keys", 32'h0, {29'h0, ind_o});
    $display("abort done");
  endtask : t_abort
  task automatic t_timeout();
    wr(8'h0C, 32'h0000_0021);
    frc_keypad_model_inst.press(HOLD + 3, 3'h7);
    @(negedge clk_sys_i);
    chk("red", 32'h1, {31'h0, ind_o.red});
    wait_dark(TMO + 20);
    chk("pend lamps", 32'h6, {29'h0, seen});
    chk("pend len", 32'h1, {31'h0, n >= TMO - 10 && n <= TMO + 2});
    rchk(8'h0C, 32'h0000_0021);
    $display("timeout done");
  endtask : t_timeout
  task automatic t_key_reset();
    wr(8'h08, 32'h7);
    wr(8'h0C, 32'h7F);
    wr(8'h10, 32'h0200_0200);
    wr(8'h1C, 32'h5);
    wr(8'h28, 32'h7);
    wr(8'h4C, 32'h55);
    wr(8'h50, 32'h3);
    tick(3'h7, 1'h1);
    tick(3'h7, 1'h1);
    d0 = dones;
    frc_keypad_model_inst.press(HOLD + 6, 3'h7);
    repeat (3) @(posedge clk_sys_i);
    frc_keypad_model_inst.press(HOLD + 4, 3'h7);
    wait_dark(40);
    chk("blink", 32'h1, {29'h0, seen});
    chk("done", d0 + 1, dones);
    chk("due", 32'h0, {31'h0, svc_due_o});
    rchk(8'h08, 32'h0);
    rchk(8'h0C, 32'h62);
    rchk(8'h10, 32'h012C_012C);
    rchk(8'h1C, 32'h0000_2710);
    rchk(8'h28, 32'h0000_016D);
    rchk(8'h2C, 32'h0);
    rchk(8'h38, 32'h0);
    rchk(8'h3C, 32'h2);
    rchk(8'h48, 32'h2);
    rchk(8'h4C, 32'h55);
    rchk(8'h50, 32'h3);
    $display("key reset done");
  endtask : t_key_reset
  task automatic t_cmd();
    wr(8'h1C, 32'h1);
    wr(8'h0C, 32'h1);
    tick(3'h1, 1'h0);
    tick(3'h1, 1'h0);
    repeat (3) @(negedge clk_sys_i);
    chk("due on", 32'h1, {31'h0, svc_due_o});
    d0 = dones;
    wr(8'h00, 32'h1);
    repeat (4) @(negedge clk_sys_i);
    chk("cmd done", d0 + 1, dones);
    chk("due off", 32'h0, {31'h0, svc_due_o});
    rchk(8'h0C, 32'h2);
    rchk(8'h1C, 32'h0000_2710);
    wait_dark(40);
    $display("command done");
  endtask : t_cmd
  task automatic t_dbl();
    wr(8'h0C, 32'h10);
    repeat (3) @(negedge clk_sys_i);
    chk("all valves", 32'h1, {31'h0, opt_o.all_valves});
    @(posedge clk_sys_i);
    double_acting_i <= 1'h1;
    repeat (4) @(negedge clk_sys_i);
    chk("double acting", 32'h0, {31'h0, opt_o.all_valves});
    $display("double acting done");
  endtask : t_dbl
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    t_defaults();
    t_abort();
    t_timeout();
    t_key_reset();
    t_cmd();
    t_dbl();
    tally_and_finish();
  end
endmodule : testbench
